// File: logic/omc_defs.svh
// named constants of the operating-mode controller
// assumes a single core clock; included by its bare name
`ifndef OMC_DEFS_SVH
`define OMC_DEFS_SVH
`define OMC_CLK_MHZ 125
`define OMC_RST_HOLD_US 1000
`define OMC_NREQ_US 150000
`define OMC_CNT_W 25
`define OMC_SEL_NORMAL 2'h0
`define OMC_SLEEP_SEL 2'h1
`define OMC_STOP_SEL 2'h2
`define OMC_BLANK_W 3
`endif

// File: logic/omc_pkg.sv
// types of the operating-mode controller
// needs nothing from omc_defs.svh; its encodings are written as literals
package omc_pkg;
    typedef enum logic [4:0] {
        MODE_RESET = 5'b00001,
        MODE_NREQ = 5'b00010,
        MODE_NORMAL = 5'b00100,
        MODE_STOP = 5'b01000,
        MODE_SLEEP = 5'b10000
    } mode_t;
    typedef struct packed {
        logic isTiming;
        logic [1:0] modeSel;
    } spi_cmd_t;
    typedef struct packed {
        logic mainReg;
        logic regReduced;
        logic linTx;
        logic linRx;
        logic linWake;
        logic lxDigital;
        logic lxWake;
        logic muxEn;
        logic lowSideEn;
        logic highSideEn;
        logic hallEn;
        logic cyclicHs;
        logic lpOsc;
        logic wdWindow;
        logic curSense;
    } func_t;
    typedef struct packed {
        logic linWake;
        logic periodic;
        logic inputChange;
    } wake_src_t;
endpackage

// File: logic/operating_mode_controller.sv
// operating-mode sequencer: reset, normal request, normal, stop, sleep
// assumes spi framing decodes register writes on spiClk and the
// watchdog timebase reports misses and window state on ref_clk
`include "omc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
// Contract
// - power-up: reset low 1 ms, then request
// - reset on vdd low outside sleep, wd fail, sleep wakes, timeout
// - request follows reset and stop wake-up
// - request: regulator on, reset high, lin rx
// - request entry starts 150 ms timer
// - timer expiry without normal command: reset
// - grounded strap: reset goes straight to normal
// - open strap: 150 ms request then normal
// - windowed watchdog only with strap resistor
// - wd fail: no service or early service
// - mode select bits choose the mode
// - normal raises supply and thermal interrupts
// - normal: lx readable, muxable, full lin
// - one spi write takes normal to sleep
// - sleep: regulator off, few wake sources
// - cyclic sense runs oscillator, pulses high side
// - sleep wake goes through reset, keeps battfail
// - stop only by command, reduced regulator
// - stop wakes five sources, sleep three
// - stop wake to request, irq unless cs/rst
// - low-power: lowside, hall, mux off
// - released external reset enters request
// - irq low until status read
module operating_mode_controller
    import omc_pkg::*;
#(
    parameter int RST_HOLD_CYC = `OMC_RST_HOLD_US * `OMC_CLK_MHZ,
    parameter int NREQ_CYC = `OMC_NREQ_US * `OMC_CLK_MHZ,
    parameter logic [1:0] SLEEP_SEL = `OMC_SLEEP_SEL,
    parameter logic [1:0] STOP_SEL = `OMC_STOP_SEL
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic spiClk,
    input wire logic spiWrValid,
    input wire spi_cmd_t spiWrCmd,
    input wire logic rstPinIn,
    output logic rstPinOut,
    output logic rstPinOe,
    input wire logic csN,
    input wire logic wdConfGnd,
    input wire logic wdConfRes,
    input wire logic vddLow,
    input wire logic wdNoService,
    input wire logic wdWindowOpen,
    input wire logic evtOverVolt,
    input wire logic evtUnderVolt,
    input wire logic evtThermal,
    input wire logic evtPrewarn,
    input wire wake_src_t wakeIn,
    input wire logic cyclicCfg,
    input wire logic statusRead,
    output mode_t mode,
    output func_t functions,
    output logic irqN,
    output wake_src_t wakeReport,
    output logic battFailFlag
);
    localparam int CW = `OMC_CNT_W;
    localparam logic [CW-1:0] HOLD_LAST = CW'(RST_HOLD_CYC - 1);
    localparam logic [CW-1:0] NREQ_LAST = CW'(NREQ_CYC - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    // link side: capture the command and flip a toggle
    spi_cmd_t spiHold;
    logic spiTgl;

    always_ff @(posedge spiClk or posedge rst) begin
        if (rst) begin
            spiHold <= '0;
            spiTgl <= 1'b0;
        end else if (spiWrValid) begin
            spiHold <= spiWrCmd;
            spiTgl <= ~spiTgl;
        end
    end

    // core side: the held word is stable two edges before the toggle shows
    logic tglMeta;
    logic tglSync;
    logic tglPrev;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tglMeta <= 1'b0;
            tglSync <= 1'b0;
            tglPrev <= 1'b0;
        end else begin
            tglMeta <= spiTgl;
            tglSync <= tglMeta;
            tglPrev <= tglSync;
        end
    end

    wire cmdValid = tglSync ^ tglPrev;
    wire modeWrite = cmdValid && !spiHold.isTiming;
    wire timingWrite = cmdValid && spiHold.isTiming;
    wire selNormal = modeWrite && (spiHold.modeSel == `OMC_SEL_NORMAL);
    wire selSleep = modeWrite && (spiHold.modeSel == SLEEP_SEL);
    wire selStop = modeWrite && (spiHold.modeSel == STOP_SEL);

    // pin synchronisers: reset line, chip select, strap levels
    logic [3:0] pinMeta;
    logic [3:0] pinSync;
    logic csPrev;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pinMeta <= 4'hf;
            pinSync <= 4'hf;
            csPrev <= 1'b1;
        end else begin
            pinMeta <= {rstPinIn, csN, wdConfGnd, wdConfRes};
            pinSync <= pinMeta;
            csPrev <= pinSync[2];
        end
    end

    wire rstLineHigh = pinSync[3];
    wire csRise = pinSync[2] && !csPrev;
    wire wdGnd = pinSync[1];
    wire wdRes = pinSync[0] && !wdGnd;
    wire wdOpen = !pinSync[0] && !wdGnd;

    // our own drive echoes back through the filter; blank it for a while
    logic [`OMC_BLANK_W-1:0] oeHist;
    wire extLow = !rstLineHigh && !rstPinOe && (oeHist == '0);

    logic [CW-1:0] cnt;
    logic extHold;
    logic timingDone;
    mode_t next_mode;

    wire inReset = (mode == MODE_RESET);
    wire inNreq = (mode == MODE_NREQ);
    wire inNormal = (mode == MODE_NORMAL);
    wire inStop = (mode == MODE_STOP);
    wire inSleep = (mode == MODE_SLEEP);

    wire wakeSleep = |wakeIn;
    wire wakeStopIrq = |wakeIn;
    wire wakeStop = wakeStopIrq || csRise || extLow;

    // miss, or service while the window is still closed
    wire wdFail = inNormal && wdRes
        && (wdNoService || (selNormal && !wdWindowOpen));
    wire resetCause = vddLow || extLow || wdFail;
    wire nreqExpired = inNreq && (cnt == NREQ_LAST);
    wire normalCmd = selNormal && timingDone;
    wire resetHoldDone = !vddLow && (cnt == HOLD_LAST);

    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_RESET: begin
                if (extHold) begin
                    if (rstLineHigh) next_mode = MODE_NREQ;
                end else if (resetHoldDone) begin
                    if (wdGnd) next_mode = MODE_NORMAL;
                    else next_mode = MODE_NREQ;
                end
            end
            MODE_NREQ: begin
                if (resetCause) next_mode = MODE_RESET;
                else if (normalCmd) next_mode = MODE_NORMAL;
                else if (nreqExpired && wdOpen) next_mode = MODE_NORMAL;
                else if (nreqExpired) next_mode = MODE_RESET;
            end
            MODE_NORMAL: begin
                if (resetCause) next_mode = MODE_RESET;
                else if (selSleep) next_mode = MODE_SLEEP;
                else if (selStop) next_mode = MODE_STOP;
            end
            MODE_STOP: begin
                if (vddLow) next_mode = MODE_RESET;
                else if (wakeStop) next_mode = MODE_NREQ;
            end
            MODE_SLEEP: begin
                if (wakeSleep) next_mode = MODE_RESET;
            end
            default: next_mode = MODE_RESET;
        endcase
    end

    wire modeChange = (next_mode != mode);
    wire cntClear = modeChange || (inReset && vddLow);
    wire [CW-1:0] next_cnt = cntClear ? CNT_ZERO : (cnt + CNT_ONE);
    wire next_extHold = (next_mode == MODE_RESET)
        && (inReset ? extHold : extLow);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode <= MODE_RESET;
            cnt <= CNT_ZERO;
            extHold <= 1'b0;
            oeHist <= '0;
        end else begin
            mode <= next_mode;
            cnt <= next_cnt;
            extHold <= next_extHold;
            oeHist <= {oeHist[`OMC_BLANK_W-2:0], rstPinOe};
        end
    end

    // timing register must be written in this request window first
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) timingDone <= 1'b0;
        else if (timingWrite) timingDone <= 1'b1;
        else if (!inNreq) timingDone <= 1'b0;
    end

    // reset line: open drain, pulled low in reset unless held outside
    wire next_rstOe = (next_mode == MODE_RESET) && !next_extHold;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rstPinOe <= 1'b1;
            rstPinOut <= 1'b0;
        end else begin
            rstPinOe <= next_rstOe;
            rstPinOut <= 1'b0;
        end
    end

    // function enables per mode, registered for clean pins
    wire lowPower = inStop || inSleep;
    wire active = inNreq || inNormal;
    func_t next_func;
    assign next_func.mainReg = !inSleep;
    assign next_func.regReduced = inStop;
    assign next_func.linTx = inNormal;
    assign next_func.linRx = active || inStop;
    assign next_func.linWake = lowPower;
    assign next_func.lxDigital = active;
    assign next_func.lxWake = lowPower;
    assign next_func.muxEn = active;
    assign next_func.lowSideEn = active;
    assign next_func.highSideEn = active;
    assign next_func.hallEn = active;
    assign next_func.cyclicHs = lowPower && cyclicCfg;
    assign next_func.lpOsc = lowPower && cyclicCfg;
    assign next_func.wdWindow = inNormal && wdRes;
    assign next_func.curSense = !lowPower;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) functions <= '0;
        else functions <= next_func;
    end

    // interrupts: set beats the acknowledging read
    logic irqPend;
    wire rstActive = rstPinOe || !rstLineHigh;
    wire supplyEvt = evtOverVolt || evtUnderVolt || evtThermal || evtPrewarn;
    wire irqSet = !rstActive && ((active && supplyEvt)
        || (inStop && wakeStopIrq));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) irqPend <= 1'b0;
        else if (irqSet) irqPend <= 1'b1;
        else if (statusRead) irqPend <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) irqN <= 1'b1;
        else irqN <= !(irqPend || irqSet);
    end

    // wake source and battery-fail reporting
    wire wakeCapture = (inSleep && wakeSleep) || (inStop && wakeStopIrq);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) wakeReport <= '0;
        else if (wakeCapture) wakeReport <= wakeReport | wakeIn;
        else if (statusRead) wakeReport <= '0;
    end

    // set only by power-on; the sleep-wake reset path never touches it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) battFailFlag <= 1'b1;
        else if (statusRead) battFailFlag <= 1'b0;
    end

    sequence s_sleepWake;
        inSleep && wakeSleep;
    endsequence

    sequence s_resetDriven;
        inReset ##1 rstPinOe;
    endsequence

    property p_holdLen;
        @(posedge ref_clk) disable iff (rst)
        (inReset && !extHold && next_mode != MODE_RESET)
            |-> (cnt == HOLD_LAST);
    endproperty
    a_holdLen: assert property (p_holdLen)
        else $error("reset released before hold count");

    property p_vddReset;
        @(posedge ref_clk) disable iff (rst)
        vddLow |=> inReset ##1 rstPinOe;
    endproperty
    a_vddReset: assert property (p_vddReset)
        else $error("vdd low did not force reset");

    property p_nreqFuncs;
        @(posedge ref_clk) disable iff (rst)
        inNreq |=> functions.mainReg && functions.linRx
            && !functions.linTx && (!rstPinOe || inReset);
    endproperty
    a_nreqFuncs: assert property (p_nreqFuncs)
        else $error("request mode functions wrong");

    property p_timeout;
        @(posedge ref_clk) disable iff (rst)
        (nreqExpired && wdRes && !normalCmd && !resetCause)
            |=> inReset;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("request timeout did not reset");

    property p_openStrap;
        @(posedge ref_clk) disable iff (rst)
        (nreqExpired && wdOpen && !resetCause) |=> inNormal;
    endproperty
    a_openStrap: assert property (p_openStrap)
        else $error("open strap did not reach normal");

    property p_gndStrap;
        @(posedge ref_clk) disable iff (rst)
        (inReset && !extHold && resetHoldDone && wdGnd) |=> inNormal;
    endproperty
    a_gndStrap: assert property (p_gndStrap)
        else $error("grounded strap did not skip request");

    property p_sleepCmd;
        @(posedge ref_clk) disable iff (rst)
        (inNormal && selSleep && !resetCause) |=> inSleep
            ##1 !functions.mainReg;
    endproperty
    a_sleepCmd: assert property (p_sleepCmd)
        else $error("sleep command not obeyed");

    property p_sleepWake;
        @(posedge ref_clk) disable iff (rst)
        s_sleepWake |=> s_resetDriven;
    endproperty
    a_sleepWake: assert property (p_sleepWake)
        else $error("sleep wake skipped reset");

    property p_stopQuietWake;
        @(posedge ref_clk) disable iff (rst)
        (inStop && csRise && !wakeStopIrq && !irqPend && !vddLow)
            |=> inNreq && !irqPend;
    endproperty
    a_stopQuietWake: assert property (p_stopQuietWake)
        else $error("cs wake handled wrongly");

    property p_irqHold;
        @(posedge ref_clk) disable iff (rst)
        (irqPend && !statusRead) |=> !irqN ##1 !irqN;
    endproperty
    a_irqHold: assert property (p_irqHold)
        else $error("irq released before status read");

    property p_lowPowerOff;
        @(posedge ref_clk) disable iff (rst)
        lowPower |=> !functions.lowSideEn && !functions.hallEn
            && !functions.muxEn;
    endproperty
    a_lowPowerOff: assert property (p_lowPowerOff)
        else $error("loads left on in low power");

    property p_wdFail;
        @(posedge ref_clk) disable iff (rst)
        (inNormal && wdRes && wdNoService) |=> inReset;
    endproperty
    a_wdFail: assert property (p_wdFail)
        else $error("watchdog miss did not reset");
endmodule
`default_nettype wire

// File: testbench/mcu_model.sv
// microcontroller side: register writes on a gated link clock, reset line
// assumes the reset line has a pull-up and both ends only pull it low
`timescale 1ns/1ns
`default_nettype none
module mcu_model
    import omc_pkg::*;
(
    output logic spiClk,
    output logic spiWrValid,
    output spi_cmd_t spiWrCmd,
    input wire logic rstPinOut,
    input wire logic rstPinOe,
    output logic rstLevel
);
    logic extLow;
    // open-drain line: any pull-down wins over the pull-up
    assign rstLevel = ((rstPinOe && !rstPinOut) || extLow) ? 1'b0 : 1'b1;
    initial begin
        spiClk = 1'b0;
        spiWrValid = 1'b0;
        spiWrCmd = '0;
        extLow = 1'b0;
    end
    // link clock only runs inside a write; idle word is inverted so a stale
    // value cannot pass for a fresh one
    task automatic spiWrite(input spi_cmd_t c);
        spiWrValid = 1'b1;
        spiWrCmd = c;
        #16 spiClk = 1'b1;
        #1 spiWrValid = 1'b0;
        spiWrCmd = spi_cmd_t'(~c);
        #15 spiClk = 1'b0;
        #64;
    endtask
    task automatic enterNormal();
        spiWrite(3'h4);
        spiWrite(3'h0);
    endtask
endmodule
`default_nettype wire

// File: testbench/operating_mode_controller_tb_top.sv
// self-checking bench of the operating-mode controller
// assumes the package, its header and mcu_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module operating_mode_controller_tb_top;
    import omc_pkg::*;
    logic ref_clk, rst, spiClk, spiWrValid, rstLevel, rstPinOut, rstPinOe;
    logic csN, wdConfGnd, wdConfRes, vddLow, wdNoService, wdWindowOpen;
    logic cyclicCfg, statusRead, irqN, battFailFlag;
    logic [3:0] evt;
    spi_cmd_t spiWrCmd;
    wake_src_t wakeIn, wakeReport;
    mode_t mode;
    func_t functions;
    int err_total = 0;
    int n_compared = 0;

    // short counts keep the run small
    operating_mode_controller #(.RST_HOLD_CYC(20), .NREQ_CYC(60)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .spiClk(spiClk), .spiWrValid(spiWrValid),
        .spiWrCmd(spiWrCmd), .rstPinIn(rstLevel), .rstPinOut(rstPinOut),
        .rstPinOe(rstPinOe), .csN(csN), .wdConfGnd(wdConfGnd), .wdConfRes(wdConfRes),
        .vddLow(vddLow), .wdNoService(wdNoService), .wdWindowOpen(wdWindowOpen),
        .evtOverVolt(evt[0]), .evtUnderVolt(evt[1]), .evtThermal(evt[2]),
        .evtPrewarn(evt[3]), .wakeIn(wakeIn), .cyclicCfg(cyclicCfg),
        .statusRead(statusRead), .mode(mode), .functions(functions), .irqN(irqN),
        .wakeReport(wakeReport), .battFailFlag(battFailFlag));
    mcu_model i_mcu (.spiClk(spiClk), .spiWrValid(spiWrValid), .spiWrCmd(spiWrCmd),
        .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .rstLevel(rstLevel));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic step(input int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic waitMode(input mode_t m, input int lim);
        for (int k = 0; k < lim && mode !== m; k++) step();
        chk("mode", mode, m);
    endtask
    task automatic waitIrq(input logic v);
        for (int k = 0; k < 8 && irqN !== v; k++) step();
        chk("irqN", irqN, v);
    endtask
    task automatic ack();
        statusRead = 1'b1;
        step();
        statusRead = 1'b0;
    endtask
    task automatic doReset(input logic g, input logic r);
        wdConfGnd = g;
        wdConfRes = r;
        rst = 1'b1;
        step(3);
        rst = 1'b0;
    endtask
    task automatic toNormal();
        i_mcu.enterNormal();
        waitMode(MODE_NORMAL, 20);
    endtask
    task automatic fin(input string s);
        $display("test %s done", s);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        $display("ERROR watchdog expected finish seen hang");
        end_of_test();
    end

    initial begin
        {rst, csN, vddLow, wdNoService, cyclicCfg, statusRead} = 6'h30;
        {wdConfGnd, wdConfRes, evt, wakeIn} = '0;
        wdWindowOpen = 1'b1;
        doReset(1'b0, 1'b1);
        chk("mode", mode, MODE_RESET);
        chk("oe", rstPinOe, 1'b1);
        chk("battfail", battFailFlag, 1'b1);
        waitMode(MODE_NREQ, 30);
        step();
        chk("oe", rstPinOe, 1'b0);
        chk("nreqfn", {functions.mainReg, functions.linTx, functions.linRx}, 3'h5);
        // mode write without the timing write must be ignored
        i_mcu.spiWrite(3'h0);
        step(10);
        chk("mode", mode, MODE_NREQ);
        waitMode(MODE_RESET, 70);
        waitMode(MODE_NREQ, 30);
        fin("timeout");
        toNormal();
        step();
        chk("nfn", {functions.mainReg, functions.regReduced, functions.linTx,
            functions.linRx, functions.wdWindow}, 5'h17);
        ack();
        chk("battfail", battFailFlag, 1'b0);
        for (int i = 0; i < 4; i++) begin
            evt = 4'h1 << i;
            step();
            evt = 4'h0;
            waitIrq(1'b0);
            ack();
            waitIrq(1'b1);
        end
        fin("irq");
        // service while the window is still closed
        wdWindowOpen = 1'b0;
        i_mcu.spiWrite(3'h0);
        waitMode(MODE_RESET, 20);
        wdWindowOpen = 1'b1;
        waitMode(MODE_NREQ, 30);
        toNormal();
        wdNoService = 1'b1;
        step();
        wdNoService = 1'b0;
        waitMode(MODE_RESET, 10);
        waitMode(MODE_NREQ, 30);
        fin("watchdog");
        toNormal();
        i_mcu.spiWrite(3'h2);
        waitMode(MODE_STOP, 20);
        step();
        chk("stopfn", {functions.mainReg, functions.regReduced, functions.lowSideEn,
            functions.hallEn, functions.muxEn}, 5'h18);
        csN = 1'b0;
        step();
        csN = 1'b1;
        waitMode(MODE_NREQ, 10);
        chk("irqN", irqN, 1'b1);
        toNormal();
        i_mcu.spiWrite(3'h2);
        waitMode(MODE_STOP, 20);
        wakeIn = 3'h1;
        step();
        wakeIn = 3'h0;
        waitMode(MODE_NREQ, 10);
        waitIrq(1'b0);
        ack();
        waitIrq(1'b1);
        toNormal();
        i_mcu.spiWrite(3'h2);
        waitMode(MODE_STOP, 20);
        i_mcu.extLow = 1'b1;
        waitMode(MODE_RESET, 10);
        chk("oe", rstPinOe, 1'b0);
        i_mcu.extLow = 1'b0;
        waitMode(MODE_NREQ, 10);
        chk("irqN", irqN, 1'b1);
        fin("stop");
        toNormal();
        vddLow = 1'b1;
        waitMode(MODE_RESET, 10);
        step();
        chk("oe", rstPinOe, 1'b1);
        vddLow = 1'b0;
        waitMode(MODE_NREQ, 30);
        toNormal();
        cyclicCfg = 1'b1;
        i_mcu.spiWrite(3'h1);
        waitMode(MODE_SLEEP, 20);
        step();
        chk("sleepfn", {functions.mainReg, functions.lowSideEn, functions.hallEn,
            functions.muxEn, functions.lpOsc, functions.cyclicHs}, 6'h03);
        csN = 1'b0;
        step();
        csN = 1'b1;
        step(6);
        chk("mode", mode, MODE_SLEEP);
        wakeIn = 3'h4;
        step();
        wakeIn = 3'h0;
        waitMode(MODE_RESET, 10);
        waitMode(MODE_NREQ, 30);
        chk("wake", wakeReport, 3'h4);
        chk("battfail", battFailFlag, 1'b0);
        fin("sleep");
        doReset(1'b1, 1'b0);
        waitMode(MODE_NORMAL, 25);
        doReset(1'b0, 1'b0);
        waitMode(MODE_NREQ, 30);
        waitMode(MODE_NORMAL, 70);
        step();
        chk("wdwin", functions.wdWindow, 1'b0);
        fin("straps");
        end_of_test();
    end
endmodule
`default_nettype wire
